/* bench/eccc_host.sv */
// Host model driving the register bus
`timescale 1ns/1ps
module eccc_host
(
	input wire logic clk_in, // Clock
	input wire logic awr_in, // AW ready
	input wire logic wr_in, // W ready
	input wire logic bv_in, // B valid
	input wire logic [1:0] bresp_in, // B code
	input wire logic arr_in, // AR ready
	input wire logic rv_in, // R valid
	input wire logic [31:0] rdata_in, // R data
	input wire logic [1:0] rresp_in, // R code
	output logic [7:0] awaddr_out = 8'h00, // AW addr
	output logic awv_out = 1'b0, // AW valid
	output logic [31:0] wdata_out = 32'h00000000, // W data
	output logic wv_out = 1'b0, // W valid
	output logic br_out = 1'b0, // B ready
	output logic [7:0] araddr_out = 8'h00, // AR addr
	output logic arv_out = 1'b0, // AR valid
	output logic rr_out = 1'b0 // R ready
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		awaddr_out <= a;
		wdata_out <= {24'h000000, d};
		awv_out <= 1'b1;
		wv_out <= 1'b1;
		br_out <= 1'b1;
		forever
		begin
			@(posedge clk_in);
			if (awr_in) awv_out <= 1'b0;
			if (wr_in) wv_out <= 1'b0;
			if (bv_in) break;
		end
		r = bresp_in;
		br_out <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		araddr_out <= a;
		arv_out <= 1'b1;
		rr_out <= 1'b1;
		forever
		begin
			@(posedge clk_in);
			if (arr_in) arv_out <= 1'b0;
			if (rv_in) break;
		end
		d = rdata_in[7:0];
		r = rresp_in;
		rr_out <= 1'b0;
		@(posedge clk_in);
	endtask : rd
	// Second canceller takes a value only as a spaced pair
	task automatic wr2(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		wr(a, d, r);
		repeat (4) @(posedge clk_in);
		wr(a, d, r);
	endtask : wr2
endmodule : eccc_host

/* bench/echo_canceller_channel_control_tb_top.sv */
// Bench for the canceller control block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected %0t got %h want %h", $time, a, e); end end
module echo_canceller_channel_control_tb_top;
	import eccc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, pd, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] wdata, rdata;
	logic [31:0] lfsr = 32'h000002A5;
	logic [7:0] awaddr, araddr, d, quiet = 8'hFF, c1 = 8'h02, c2 = 8'h00;
	logic [15:0] modes [8] = '{16'h0200, 16'h0A00, 16'h0600, 16'h0A03, 16'h0202, 16'h0201,
		16'h0204, 16'h02A8};
	eccc_pcm_type [1:0] pin = '0, pout, feed;
	eccc_core_type [1:0] core = '0;
	eccc_knob_type [1:0] knob;
	int bad_count = 0, num_checks = 0, cyc = 0;
	eccc_top dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rr), .PCM_IN(pin), .CORE_IN(core), .PCM_OUT(pout),
		.FEED_OUT(feed), .KNOB_OUT(knob), .TONE_POWER_DOWN_OUT(pd), .IRQ_OUT(irq));
	eccc_host host (.clk_in(clk), .awr_in(awr), .wr_in(wrd), .bv_in(bv), .bresp_in(bresp),
		.arr_in(arr), .rv_in(rv), .rdata_in(rdata), .rresp_in(rresp), .awaddr_out(awaddr),
		.awv_out(awv), .wdata_out(wdata), .wv_out(wv), .br_out(br), .araddr_out(araddr),
		.arv_out(arv), .rr_out(rr));
	initial forever #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			give_verdict;
		end
	end
	// ==========================================
	// Model and helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic logic [7:0] exp_out(input logic m, input logic [7:0] raw, input logic [7:0] p);
		exp_out = m ? quiet : (c1[3] ? raw : p);
	endfunction : exp_out
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		host.wr(a, v, resp);
		`CHK(resp, 2'h0)
		if (a == 8'h00) c1 = v;
		if (a == 8'h04) c2 = v;
	endtask : put
	task automatic samp;
		lfsr = nxt(lfsr);
		pin[0] <= {1'b1, lfsr[15:0]};
		pin[1] <= {1'b1, lfsr[15:0]};
		core[0] <= {~lfsr, 3'b000};
		core[1] <= {lfsr[31:16], ~lfsr[15:0], 3'b000};
		@(posedge clk);
		pin[0].valid <= 1'b0;
		pin[1].valid <= 1'b0;
		@(negedge clk);
		`CHK(pout[0].send, exp_out(c2[1], lfsr[15:8], ~lfsr[31:24]))
		`CHK(pout[0].recv, exp_out(c2[0], lfsr[7:0], ~lfsr[23:16]))
		`CHK({feed[0].send, feed[0].recv}, c2[2] ? lfsr[15:0] : ~lfsr[15:0])
		`CHK(knob[0][5:3], {c1[3], ~c1[3] & ~c1[2], ~c1[3]})
		`CHK(knob[0][2:0], ~{c2[7], c2[5], c2[3]})
		`CHK({pout[1].send, pout[1].recv}, lfsr[31:16])
		`CHK({feed[1].send, feed[1].recv}, ~lfsr[15:0])
		`CHK(knob[1], 6'h1F)
		@(posedge clk);
	endtask : samp
	task automatic give_verdict;
		if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		host.rd(8'h00, d, resp);
		`CHK(d, 8'h02)
		host.rd(8'h3C, d, resp);
		`CHK(resp, 2'h2)
		foreach (modes[i])
		begin
			put(8'h00, modes[i][15:8]);
			put(8'h04, modes[i][7:0]);
			repeat (2) samp;
		end
		put(8'h04, 8'h03);
		for (int l = 1; l < 3; l++)
		begin
			put(8'h24, l[7:0]);
			quiet = (l == 1) ? 8'hD5 : 8'h80;
			samp;
		end
		put(8'h04, 8'h80);
		`CHK(pd, 1'b0)
		host.wr2(8'h0C, 8'h80, resp);
		@(posedge clk);
		`CHK(pd, 1'b1)
		host.rd(8'h0C, d, resp);
		`CHK(d, 8'h80)
		host.wr(8'h08, 8'h0A, resp);
		host.wr(8'h08, 8'h0E, resp);
		host.rd(8'h18, d, resp);
		`CHK(d, 8'h10)
		host.rd(8'h08, d, resp);
		`CHK(d, 8'h02)
		host.wr(8'h1C, 8'h01, resp);
		put(8'h04, 8'h10);
		core[0].tone_present <= 1'b1;
		repeat (2) @(posedge clk);
		host.rd(8'h10, d, resp);
		`CHK(d, 8'h00)
		core[0].phase_reversal <= 1'b1;
		repeat (3) @(posedge clk);
		host.rd(8'h10, d, resp);
		`CHK(d, 8'h42)
		`CHK(irq, 1'b1)
		host.wr(8'h20, 8'h01, resp);
		`CHK(irq, 1'b0)
		put(8'h04, 8'h50);
		core[0].phase_reversal <= 1'b0;
		repeat (2) @(posedge clk);
		host.rd(8'h10, d, resp);
		`CHK(d, 8'h42)
		put(8'h04, 8'h40);
		host.rd(8'h10, d, resp);
		`CHK(d, 8'h40)
		give_verdict;
	end
endmodule : echo_canceller_channel_control_tb_top

/* hw/eccc_chan.sv */
// One canceller: output selection, input routing, core knobs and tone flags
`timescale 1ns/1ps
module eccc_chan
(
	input wire logic clk_in, // Block clock
	input wire logic rst_n_in, // Asynchronous reset, active low
	input wire eccc_pkg::eccc_ctl_one_type ctl_one_in, // First control byte
	input wire eccc_pkg::eccc_ctl_two_type ctl_two_in, // Second control byte
	input wire eccc_pkg::eccc_law_type law_in, // PCM encoding
	input wire eccc_pkg::eccc_pcm_type pcm_in, // Input samples
	input wire eccc_pkg::eccc_core_type core_in, // Core results
	output eccc_pkg::eccc_pcm_type pcm_out, // Output samples
	output eccc_pkg::eccc_pcm_type feed_out, // Samples into the canceller
	output eccc_pkg::eccc_knob_type knob_out, // Core controls
	output eccc_pkg::eccc_flag_type flags_out // Detector flags
);
	import eccc_pkg::*;
	eccc_chan_state_type st_reg;
	eccc_chan_state_type st_next;
	logic [7:0] quiet;
	always_comb
	begin
		st_next = st_reg;
		quiet = eccc_quiet(law_in);
		st_next.pcm.valid = pcm_in.valid;
		st_next.feed.valid = pcm_in.valid;
		if (pcm_in.valid)
		begin
			// Mute wins over bypass
			if (ctl_two_in.send_mute)
				st_next.pcm.send = quiet; // [R12]
			else if (ctl_one_in.bypass)
				st_next.pcm.send = pcm_in.send; // [R1]
			else
				st_next.pcm.send = core_in.send_proc; // [R3] [R13]
			if (ctl_two_in.receive_mute)
				st_next.pcm.recv = quiet; // [R14]
			else if (ctl_one_in.bypass)
				st_next.pcm.recv = pcm_in.recv; // [R1]
			else
				st_next.pcm.recv = core_in.recv_proc; // [R3] [R14]
			st_next.feed.send = ctl_two_in.offset_filter_bypass_bit ? pcm_in.send :
				core_in.send_hpf; // [R10] [R11]
			st_next.feed.recv = ctl_two_in.offset_filter_bypass_bit ? pcm_in.recv :
				core_in.recv_hpf; // [R10] [R11]
		end
		st_next.knob.coef_zero = ctl_one_in.bypass; // [R2]
		st_next.knob.adapt_enable = !ctl_one_in.bypass && !ctl_one_in.adaptation_disable; // [R2] [R4] [R5]
		st_next.knob.echo_subtract = !ctl_one_in.bypass; // [R4]
		st_next.knob.tone_enable = !ctl_two_in.tone_detect_disable; // [R6]
		st_next.knob.nlp_enable = !ctl_two_in.nonlinear_processor_disable; // [R15]
		st_next.knob.nb_enable = !ctl_two_in.narrowband_detector_disable; // [R15]
		st_next.flags.tone = !ctl_two_in.tone_detect_disable && core_in.tone_present &&
			(ctl_two_in.phase_qualification_disable || core_in.phase_reversal); // [R8] [R9]
		st_next.flags.gated = ctl_two_in.automatic_tone_handling && st_next.flags.tone; // [R16]
		st_next.flags.nb = !ctl_two_in.narrowband_detector_disable && core_in.narrowband; // [R15]
	end
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign pcm_out = st_reg.pcm;
	assign feed_out = st_reg.feed;
	assign knob_out = st_reg.knob;
	assign flags_out = st_reg.flags;
endmodule : eccc_chan

/* hw/eccc_params.svh */
// Offsets, field positions, reset values and timing counts of the canceller control block
// Contract
// [R1] Bypass passes send and receive inputs unchanged to their outputs.
// [R2] Bypass holds filter coefficients at zero and stops adaptation.
// [R3] Without bypass, both outputs carry the cancellation processing result.
// [R4] Adaptation disable freezes coefficients while echo is still subtracted.
// [R5] Adaptation enabled keeps coefficients tracking the echo path.
// [R6] Tone detect disable stops tone detection; clearing it restarts detection.
// [R7] Both cancellers tone-disabled powers down the shared tone processors.
// [R8] Phase qualification disabled: tone detector fires on any 2100 Hz tone.
// [R9] Phase qualification enabled: detector fires only with periodic phase reversals.
// [R10] Offset filter bypass routes both input samples around the offset filters.
// [R11] Offset filter bypass clear keeps the offset filters in both inputs.
// [R12] Send mute replaces every send output sample with quiet code.
// [R13] Send mute clear lets processed samples reach the send output.
// [R14] Receive mute forces quiet code on receive output; clearing restores samples.
// [R15] Disable bits stop the non-linear processor and narrow-band detector.
// [R16] Gated tone flag high only with automatic tone handling and tone present.
// [R17] Host writes second canceller controls twice, 350 ns to 20 us apart.
`ifndef ECCC_PARAMS_SVH
`define ECCC_PARAMS_SVH
// ==========================================
// Register byte offsets
`define ECCC_OFS_CTL1_FIRST 8'h00
`define ECCC_OFS_CTL2_FIRST 8'h04
`define ECCC_OFS_CTL1_SECOND 8'h08
`define ECCC_OFS_CTL2_SECOND 8'h0C
`define ECCC_OFS_STAT_FIRST 8'h10
`define ECCC_OFS_STAT_SECOND 8'h14
`define ECCC_OFS_IRQ_STATUS 8'h18
`define ECCC_OFS_IRQ_ENABLE 8'h1C
`define ECCC_OFS_IRQ_CLEAR 8'h20
`define ECCC_OFS_LAW 8'h24
// ==========================================
// Reset values, fields, codes
`define ECCC_RST_CTL1 8'h02
`define ECCC_RST_CTL2 8'h00
`define ECCC_STAT_TONE 6
`define ECCC_STAT_GATED 1
`define ECCC_STAT_NB 0
`define ECCC_IRQ_W 5
`define ECCC_QUIET_MU 8'hFF
`define ECCC_QUIET_A 8'hD5
`define ECCC_QUIET_SIGN 8'h80
`define ECCC_RESP_OKAY 2'h0
`define ECCC_RESP_SLVERR 2'h2
// ==========================================
// Timing
`define ECCC_CLK_NS 100
`define ECCC_DW_MIN_NS 350
`define ECCC_DW_MAX_NS 20000
`define ECCC_DW_MIN_CYC ((`ECCC_DW_MIN_NS + `ECCC_CLK_NS - 1) / `ECCC_CLK_NS)
`define ECCC_DW_MAX_CYC (`ECCC_DW_MAX_NS / `ECCC_CLK_NS)
`endif

/* hw/eccc_pkg.sv */
// Types shared by the canceller control block
`include "eccc_params.svh"
package eccc_pkg;
	typedef enum logic [1:0]
	{
		ECCC_LAW_MU = 2'h0,
		ECCC_LAW_A = 2'h1,
		ECCC_LAW_SIGN = 2'h2
	} eccc_law_type;
	typedef struct packed
	{
		logic reset_req;
		logic noise_inject_disable;
		logic back_to_back;
		logic pad;
		logic bypass;
		logic adaptation_disable;
		logic fixed_one;
		logic fixed_zero;
	} eccc_ctl_one_type;
	typedef struct packed
	{
		logic tone_detect_disable;
		logic phase_qualification_disable;
		logic nonlinear_processor_disable;
		logic automatic_tone_handling;
		logic narrowband_detector_disable;
		logic offset_filter_bypass_bit;
		logic send_mute;
		logic receive_mute;
	} eccc_ctl_two_type;
	typedef struct packed
	{
		logic valid;
		logic [7:0] send;
		logic [7:0] recv;
	} eccc_pcm_type;
	typedef struct packed
	{
		logic [7:0] send_proc;
		logic [7:0] recv_proc;
		logic [7:0] send_hpf;
		logic [7:0] recv_hpf;
		logic tone_present;
		logic phase_reversal;
		logic narrowband;
	} eccc_core_type;
	typedef struct packed
	{
		logic coef_zero;
		logic adapt_enable;
		logic echo_subtract;
		logic tone_enable;
		logic nlp_enable;
		logic nb_enable;
	} eccc_knob_type;
	typedef struct packed
	{
		logic tone;
		logic gated;
		logic nb;
	} eccc_flag_type;
	typedef struct packed
	{
		eccc_pcm_type pcm;
		eccc_pcm_type feed;
		eccc_knob_type knob;
		eccc_flag_type flags;
	} eccc_chan_state_type;
	typedef struct packed
	{
		logic awrdy;
		logic wrdy;
		logic aw_held;
		logic w_held;
		logic [7:0] aw_addr;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		eccc_ctl_one_type [1:0] ctl_one;
		eccc_ctl_two_type [1:0] ctl_two;
		eccc_law_type law;
		logic [`ECCC_IRQ_W-1:0] irq_status;
		logic [`ECCC_IRQ_W-1:0] irq_enable;
		logic irq;
		logic power_down;
		logic dw_pend;
		logic dw_sel;
		logic [7:0] dw_data;
		logic [7:0] dw_cnt;
		logic [1:0] gated_prev;
		logic [1:0] nb_prev;
	} eccc_top_state_type;
	function automatic logic [7:0] eccc_quiet(input eccc_law_type law);
		case (law)
			ECCC_LAW_MU: eccc_quiet = `ECCC_QUIET_MU;
			ECCC_LAW_A: eccc_quiet = `ECCC_QUIET_A;
			default: eccc_quiet = `ECCC_QUIET_SIGN;
		endcase
	endfunction : eccc_quiet
endpackage : eccc_pkg

/* hw/eccc_top.sv */
// Top of the canceller pair control block: register slave, pair logic, interrupt
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eccc_params.svh"
module eccc_top
(
	input wire logic REF_CLK_IN, // 10 MHz block clock
	input wire logic RST_N_IN, // Asynchronous reset, active low
	input wire logic [7:0] S_AXI_AWADDR_IN, // Write address
	input wire logic S_AXI_AWVALID_IN, // Write address valid
	output logic S_AXI_AWREADY_OUT, // Write address ready
	input wire logic [31:0] S_AXI_WDATA_IN, // Write data
	input wire logic [3:0] S_AXI_WSTRB_IN, // Write byte strobes
	input wire logic S_AXI_WVALID_IN, // Write data valid
	output logic S_AXI_WREADY_OUT, // Write data ready
	output logic [1:0] S_AXI_BRESP_OUT, // Write response
	output logic S_AXI_BVALID_OUT, // Write response valid
	input wire logic S_AXI_BREADY_IN, // Write response ready
	input wire logic [7:0] S_AXI_ARADDR_IN, // Read address
	input wire logic S_AXI_ARVALID_IN, // Read address valid
	output logic S_AXI_ARREADY_OUT, // Read address ready
	output logic [31:0] S_AXI_RDATA_OUT, // Read data
	output logic [1:0] S_AXI_RRESP_OUT, // Read response
	output logic S_AXI_RVALID_OUT, // Read data valid
	input wire logic S_AXI_RREADY_IN, // Read data ready
	input wire eccc_pkg::eccc_pcm_type [1:0] PCM_IN, // Input samples per canceller
	input wire eccc_pkg::eccc_core_type [1:0] CORE_IN, // Core results per canceller
	output eccc_pkg::eccc_pcm_type [1:0] PCM_OUT, // Output samples per canceller
	output eccc_pkg::eccc_pcm_type [1:0] FEED_OUT, // Canceller input samples
	output eccc_pkg::eccc_knob_type [1:0] KNOB_OUT, // Core controls per canceller
	output logic TONE_POWER_DOWN_OUT, // Shared tone processors powered down
	output logic IRQ_OUT // Interrupt, active high level
);
	import eccc_pkg::*;
	localparam logic [7:0] DW_MIN = 8'(`ECCC_DW_MIN_CYC);
	localparam logic [7:0] DW_MAX = 8'(`ECCC_DW_MAX_CYC);
	eccc_top_state_type st_reg;
	eccc_top_state_type st_next;
	eccc_flag_type [1:0] chan_flags;
	logic do_wr;
	logic dw_hit;
	logic dw_tgt;
	logic dw_ok;
	logic dw_fault;
	logic [`ECCC_IRQ_W-1:0] irq_clr;
	logic [`ECCC_IRQ_W-1:0] irq_ev;
	logic [7:0] stat_first;
	logic [7:0] stat_second;

	// ==========================================
	// Status bytes
	always_comb
	begin
		stat_first = 8'h00;
		stat_first[`ECCC_STAT_TONE] = chan_flags[0].tone;
		stat_first[`ECCC_STAT_GATED] = chan_flags[0].gated; // [R16]
		stat_first[`ECCC_STAT_NB] = chan_flags[0].nb;
		stat_second = 8'h00;
		stat_second[`ECCC_STAT_TONE] = chan_flags[1].tone;
		stat_second[`ECCC_STAT_GATED] = chan_flags[1].gated; // [R16]
		stat_second[`ECCC_STAT_NB] = chan_flags[1].nb;
	end

	// ==========================================
	// Register slave, paired writes, interrupt
	always_comb
	begin
		st_next = st_reg;
		do_wr = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
		dw_hit = 1'b0;
		dw_tgt = 1'b0;
		irq_clr = '0;
		// Channel handshakes
		if (S_AXI_AWVALID_IN && st_reg.awrdy)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && st_reg.wrdy)
		begin
			st_next.w_held = 1'b1;
			st_next.w_data = S_AXI_WDATA_IN[7:0];
			st_next.w_lane = S_AXI_WSTRB_IN[0];
		end
		if (S_AXI_BREADY_IN && st_reg.bvalid)
			st_next.bvalid = 1'b0;
		// Write decode
		if (do_wr)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `ECCC_RESP_OKAY;
			if (st_reg.aw_addr == `ECCC_OFS_CTL1_FIRST)
			begin
				if (st_reg.w_lane)
					st_next.ctl_one[0] = eccc_ctl_one_type'(st_reg.w_data);
			end
			else if (st_reg.aw_addr == `ECCC_OFS_CTL2_FIRST)
			begin
				if (st_reg.w_lane)
					st_next.ctl_two[0] = eccc_ctl_two_type'(st_reg.w_data);
			end
			else if (st_reg.aw_addr == `ECCC_OFS_CTL1_SECOND)
			begin
				dw_hit = st_reg.w_lane;
				dw_tgt = 1'b0;
			end
			else if (st_reg.aw_addr == `ECCC_OFS_CTL2_SECOND)
			begin
				dw_hit = st_reg.w_lane;
				dw_tgt = 1'b1;
			end
			else if (st_reg.aw_addr == `ECCC_OFS_IRQ_ENABLE)
			begin
				if (st_reg.w_lane)
					st_next.irq_enable = st_reg.w_data[`ECCC_IRQ_W-1:0];
			end
			else if (st_reg.aw_addr == `ECCC_OFS_IRQ_CLEAR)
			begin
				if (st_reg.w_lane)
					irq_clr = st_reg.w_data[`ECCC_IRQ_W-1:0];
			end
			else if (st_reg.aw_addr == `ECCC_OFS_LAW)
			begin
				if (st_reg.w_lane)
					st_next.law = eccc_law_type'(st_reg.w_data[1:0]);
			end
			else if (st_reg.aw_addr == `ECCC_OFS_STAT_FIRST ||
				st_reg.aw_addr == `ECCC_OFS_STAT_SECOND ||
				st_reg.aw_addr == `ECCC_OFS_IRQ_STATUS)
			begin
				// Read-only, write ignored
				st_next.bresp = `ECCC_RESP_OKAY;
			end
			else
				st_next.bresp = `ECCC_RESP_SLVERR;
		end
		// Second canceller takes a value only from a matching pair of writes
		dw_ok = dw_hit && st_reg.dw_pend && st_reg.dw_sel == dw_tgt &&
			st_reg.dw_data == st_reg.w_data &&
			st_reg.dw_cnt >= DW_MIN && st_reg.dw_cnt <= DW_MAX; // [R17]
		dw_fault = dw_hit && st_reg.dw_pend && !dw_ok;
		if (st_reg.dw_pend)
		begin
			if (st_reg.dw_cnt == DW_MAX)
				st_next.dw_pend = 1'b0; // [R17]
			else
				st_next.dw_cnt = st_reg.dw_cnt + 8'h01;
		end
		if (dw_ok)
		begin
			st_next.dw_pend = 1'b0;
			if (dw_tgt)
				st_next.ctl_two[1] = eccc_ctl_two_type'(st_reg.w_data); // [R17]
			else
				st_next.ctl_one[1] = eccc_ctl_one_type'(st_reg.w_data); // [R17]
		end
		else if (dw_hit)
		begin
			// First of a pair, or a broken pair restarting
			st_next.dw_pend = 1'b1;
			st_next.dw_sel = dw_tgt;
			st_next.dw_data = st_reg.w_data;
			st_next.dw_cnt = 8'h01;
		end
		st_next.awrdy = !st_next.aw_held && !st_next.bvalid;
		st_next.wrdy = !st_next.w_held && !st_next.bvalid;
		// Read side
		if (S_AXI_RREADY_IN && st_reg.rvalid)
			st_next.rvalid = 1'b0;
		if (S_AXI_ARVALID_IN && st_reg.arrdy)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `ECCC_RESP_OKAY;
			st_next.rdata = 8'h00;
			if (S_AXI_ARADDR_IN == `ECCC_OFS_CTL1_FIRST)
				st_next.rdata = st_reg.ctl_one[0];
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_CTL2_FIRST)
				st_next.rdata = st_reg.ctl_two[0];
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_CTL1_SECOND)
				st_next.rdata = st_reg.ctl_one[1];
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_CTL2_SECOND)
				st_next.rdata = st_reg.ctl_two[1];
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_STAT_FIRST)
				st_next.rdata = stat_first;
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_STAT_SECOND)
				st_next.rdata = stat_second;
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_IRQ_STATUS)
				st_next.rdata = {3'h0, st_reg.irq_status};
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_IRQ_ENABLE)
				st_next.rdata = {3'h0, st_reg.irq_enable};
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_IRQ_CLEAR)
				st_next.rdata = 8'h00;
			else if (S_AXI_ARADDR_IN == `ECCC_OFS_LAW)
				st_next.rdata = {6'h00, st_reg.law};
			else
				st_next.rresp = `ECCC_RESP_SLVERR;
		end
		st_next.arrdy = !st_next.rvalid;
		// Events: set wins over a clear in the same cycle
		irq_ev = {dw_fault,
			chan_flags[1].nb && !st_reg.nb_prev[1],
			chan_flags[0].nb && !st_reg.nb_prev[0],
			chan_flags[1].gated && !st_reg.gated_prev[1],
			chan_flags[0].gated && !st_reg.gated_prev[0]};
		st_next.gated_prev = {chan_flags[1].gated, chan_flags[0].gated};
		st_next.nb_prev = {chan_flags[1].nb, chan_flags[0].nb};
		st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_ev;
		st_next.irq = |(st_next.irq_status & st_next.irq_enable);
		st_next.power_down = st_reg.ctl_two[0].tone_detect_disable &&
			st_reg.ctl_two[1].tone_detect_disable; // [R7]
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			st_reg <= '0;
			st_reg.ctl_one <= {`ECCC_RST_CTL1, `ECCC_RST_CTL1};
			st_reg.ctl_two <= {`ECCC_RST_CTL2, `ECCC_RST_CTL2};
		end
		else
			st_reg <= st_next;
	end

	assign S_AXI_AWREADY_OUT = st_reg.awrdy;
	assign S_AXI_WREADY_OUT = st_reg.wrdy;
	assign S_AXI_BRESP_OUT = st_reg.bresp;
	assign S_AXI_BVALID_OUT = st_reg.bvalid;
	assign S_AXI_ARREADY_OUT = st_reg.arrdy;
	assign S_AXI_RDATA_OUT = {24'h000000, st_reg.rdata};
	assign S_AXI_RRESP_OUT = st_reg.rresp;
	assign S_AXI_RVALID_OUT = st_reg.rvalid;
	assign TONE_POWER_DOWN_OUT = st_reg.power_down;
	assign IRQ_OUT = st_reg.irq;

	// ==========================================
	// Canceller channels
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			eccc_chan u_chan
			(
				.clk_in(REF_CLK_IN),
				.rst_n_in(RST_N_IN),
				.ctl_one_in(st_reg.ctl_one[g]),
				.ctl_two_in(st_reg.ctl_two[g]),
				.law_in(st_reg.law),
				.pcm_in(PCM_IN[g]),
				.core_in(CORE_IN[g]),
				.pcm_out(PCM_OUT[g]),
				.feed_out(FEED_OUT[g]),
				.knob_out(KNOB_OUT[g]),
				.flags_out(chan_flags[g])
			);
			a_bypass_pass: // [R1]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && st_reg.ctl_one[g].bypass && !st_reg.ctl_two[g].send_mute &&
				!st_reg.ctl_two[g].receive_mute
				|=> PCM_OUT[g].send == $past(PCM_IN[g].send) &&
				PCM_OUT[g].recv == $past(PCM_IN[g].recv))
				else $error("bypass did not copy inputs");
			a_coef_zero: // [R2]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				st_reg.ctl_one[g].bypass |=> KNOB_OUT[g].coef_zero && !KNOB_OUT[g].adapt_enable)
				else $error("bypass left coefficients or adaptation live");
			a_proc_path: // [R3]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && !st_reg.ctl_one[g].bypass && !st_reg.ctl_two[g].send_mute
				|=> PCM_OUT[g].send == $past(CORE_IN[g].send_proc))
				else $error("send output not from processing");
			a_adapt_freeze: // [R4]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				st_reg.ctl_one[g].adaptation_disable && !st_reg.ctl_one[g].bypass
				|=> !KNOB_OUT[g].adapt_enable && KNOB_OUT[g].echo_subtract)
				else $error("frozen canceller adapting or not subtracting");
			a_adapt_run: // [R5]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				!st_reg.ctl_one[g].adaptation_disable && !st_reg.ctl_one[g].bypass
				|=> KNOB_OUT[g].adapt_enable)
				else $error("adaptation not running");
			a_tone_gate: // [R6]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				st_reg.ctl_two[g].tone_detect_disable |=> !KNOB_OUT[g].tone_enable &&
				!chan_flags[g].tone)
				else $error("tone detection active while disabled");
			a_tone_any: // [R8]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				!st_reg.ctl_two[g].tone_detect_disable &&
				st_reg.ctl_two[g].phase_qualification_disable && CORE_IN[g].tone_present
				|=> chan_flags[g].tone)
				else $error("unqualified tone missed");
			a_tone_qual: // [R9]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				!st_reg.ctl_two[g].phase_qualification_disable && !CORE_IN[g].phase_reversal
				|=> !chan_flags[g].tone)
				else $error("tone flagged without phase reversal");
			a_hpf_route: // [R10]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && st_reg.ctl_two[g].offset_filter_bypass_bit
				|=> FEED_OUT[g].send == $past(PCM_IN[g].send) &&
				FEED_OUT[g].recv == $past(PCM_IN[g].recv))
				else $error("offset filter not bypassed");
			a_hpf_keep: // [R11]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && !st_reg.ctl_two[g].offset_filter_bypass_bit
				|=> FEED_OUT[g].send == $past(CORE_IN[g].send_hpf))
				else $error("offset filter dropped");
			a_send_mute: // [R12]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && st_reg.ctl_two[g].send_mute
				|=> PCM_OUT[g].send == eccc_quiet($past(st_reg.law)))
				else $error("send not muted to quiet code");
			a_recv_mute: // [R14]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				PCM_IN[g].valid && st_reg.ctl_two[g].receive_mute
				|=> PCM_OUT[g].recv == eccc_quiet($past(st_reg.law)))
				else $error("receive not muted to quiet code");
			a_nlp_off: // [R15]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				st_reg.ctl_two[g].nonlinear_processor_disable |=> !KNOB_OUT[g].nlp_enable)
				else $error("non-linear processor still enabled");
			a_nb_off: // [R15]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				st_reg.ctl_two[g].narrowband_detector_disable |=> !KNOB_OUT[g].nb_enable &&
				!chan_flags[g].nb)
				else $error("narrow-band detector still enabled");
			a_gated_flag: // [R16]
			assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
				chan_flags[g].gated |-> chan_flags[g].tone &&
				$past(st_reg.ctl_two[g].automatic_tone_handling))
				else $error("gated tone flag without its causes");
		end
	endgenerate

	// ==========================================
	// Pair and interrupt checks
	a_pair_power: // [R7]
	assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		st_reg.ctl_two[0].tone_detect_disable && st_reg.ctl_two[1].tone_detect_disable
		|=> TONE_POWER_DOWN_OUT)
		else $error("tone processors not powered down");
	a_pair_wake: // [R7]
	assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		!(st_reg.ctl_two[0].tone_detect_disable && st_reg.ctl_two[1].tone_detect_disable)
		|=> !TONE_POWER_DOWN_OUT)
		else $error("tone processors down while one canceller needs them");
	a_dw_commit: // [R17]
	assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		dw_ok && dw_tgt |=> st_reg.ctl_two[1] == $past(st_reg.w_data) && !st_reg.dw_pend)
		else $error("paired write not committed");
	a_dw_reject: // [R17]
	assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		dw_hit && !dw_ok |=> $stable(st_reg.ctl_one[1]) && $stable(st_reg.ctl_two[1]))
		else $error("unpaired write reached second canceller");
	a_irq_level:
	assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
		|(st_reg.irq_status & st_reg.irq_enable) |-> IRQ_OUT)
		else $error("enabled event without interrupt");
endmodule : eccc_top
